// File: core/dib_cfg.svh
// Timing and field constants for the inter-bank command checker.
// Assumes a 250 MHz device clock; times are kept in picoseconds.
`ifndef DIB_CFG_SVH
`define DIB_CFG_SVH

`define DIB_CLK_PERIOD_PS   4000
`define DIB_T_RCD_PS        15000
`define DIB_T_RP_PS         15000
`define DIB_T_WR_PS         15000
`define DIB_T_WTR_PS        7500
`define DIB_T_XSNR_PS       137500
`define DIB_WTR_MIN_CYC     2

// Least times round up to whole cycles
`define DIB_CYC_UP(ps)      (((ps) + `DIB_CLK_PERIOD_PS - 1) / `DIB_CLK_PERIOD_PS)
`define DIB_RCD_CYC         `DIB_CYC_UP(`DIB_T_RCD_PS)
`define DIB_RP_CYC          `DIB_CYC_UP(`DIB_T_RP_PS)
`define DIB_WR_CYC          `DIB_CYC_UP(`DIB_T_WR_PS)
`define DIB_WTR_CYC         ((`DIB_CYC_UP(`DIB_T_WTR_PS) > `DIB_WTR_MIN_CYC) ? \
                             `DIB_CYC_UP(`DIB_T_WTR_PS) : `DIB_WTR_MIN_CYC)
`define DIB_XSNR_CYC        `DIB_CYC_UP(`DIB_T_XSNR_PS)

`define DIB_READ_LATENCY    4
`define DIB_BURST_LENGTH    4
`define DIB_NUM_BANKS       8
`define DIB_CNT_W           8

`endif

// File: core/dib_pkg.sv
// Types shared by the inter-bank command checker.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package dib_pkg;

	typedef enum logic [3:0] {
		DIB_CMD_DESELECT,
		DIB_CMD_NOP,
		DIB_CMD_ACTIVATE,
		DIB_CMD_READ,
		DIB_CMD_WRITE,
		DIB_CMD_PRECHARGE,
		DIB_CMD_REFRESH,
		DIB_CMD_LOAD_MODE,
		DIB_CMD_SELF_REFRESH,
		DIB_CMD_OTHER
	} dib_cmd_e;

	typedef enum logic [2:0] {
		DIB_BANK_IDLE,
		DIB_BANK_ACTIVATING,
		DIB_BANK_ACTIVE,
		DIB_BANK_READING,
		DIB_BANK_WRITING,
		DIB_BANK_RD_AP_ACCESS,
		DIB_BANK_WR_AP_ACCESS,
		DIB_BANK_PRECHARGING
	} dib_bank_e;

	typedef struct packed {
		logic chip_select_n;
		logic row_strobe_n;
		logic col_strobe_n;
		logic write_enable_n;
		logic clock_enable;
		logic auto_precharge_select_bit;
		logic [2:0] bank_addr;
	} dib_pins_s;

	typedef struct packed {
		dib_cmd_e   cmd;
		logic [2:0] bank;
		logic       auto_pre;
	} dib_cmd_s;

endpackage : dib_pkg

`default_nettype wire

// File: core/dib_interbank.sv
// Inter-bank command decode, per-bank state tracking and legality checking
// for a DDR2-style device. Command pins are sampled on the rising ref_clk edge.
// Assumes the controller holds each command for exactly one cycle.
//
// Functional notes
// - Commands decode from chip select, strobes, write enable, clock enable at clock edge.
// - Chip select high takes no new command; running operations carry on.
// - Select low with all strobes high is a no-operation; operations carry on.
// - Permissions hold only with clock enable high twice and exit delay elapsed.
// - Idle reference bank lets other banks take whatever their own state allows.
// - Busy reference bank allows activate, read, write, precharge to other banks.
// - During auto precharge burst, other-bank commands accepted if transfer uninterrupted.
// - Read auto precharge starts precharge at earliest legal explicit precharge point.
// - Write auto precharge starts precharge when write recovery time ends.
// - Auto precharge access period runs from registration to precharge start.
// - Address bit ten on read or write selects auto precharge.
`default_nettype none

`include "dib_cfg.svh"

module dib_interbank
	import dib_pkg::*;
#(
	parameter int READ_LATENCY = `DIB_READ_LATENCY,
	parameter int BURST_LENGTH = `DIB_BURST_LENGTH,
	parameter int NUM_BANKS    = `DIB_NUM_BANKS,
	parameter int CNT_W        = `DIB_CNT_W
) (
	// Clock and reset
	input  wire logic                       ref_clk,
	input  wire logic                       rst,
	// Command pins
	input  wire dib_pins_s                  pins,
	// Decoded command and verdict
	output logic                            cmd_accept_q,
	output logic                            cmd_reject_q,
	output var dib_cmd_s                    last_cmd_q,
	// Tracker state
	output var dib_bank_e [NUM_BANKS-1:0]   bank_state_q,
	output logic                            all_idle_q,
	output logic                            self_refresh_q,
	output logic                            exit_pending_q
);

	////////////////////////////////////////////////////////////////////////////
	// Derived counts

	localparam int HALF_BL   = BURST_LENGTH / 2;
	localparam int WR_ACCESS = (READ_LATENCY - 1) + HALF_BL + `DIB_WR_CYC;
	localparam int WRAP_RD   = (READ_LATENCY - 1) + HALF_BL + `DIB_WTR_CYC;
	localparam int RDAP_WR   = HALF_BL + 2;
	localparam int CNT_MAX   = (1 << CNT_W) - 1;
	localparam logic [CNT_W-1:0] RCD_LD  = CNT_W'(`DIB_RCD_CYC);
	localparam logic [CNT_W-1:0] RP_LD   = CNT_W'(`DIB_RP_CYC);
	localparam logic [CNT_W-1:0] HBL_LD  = CNT_W'(HALF_BL);
	localparam logic [CNT_W-1:0] WRA_LD  = CNT_W'(WR_ACCESS);
	localparam logic [CNT_W-1:0] XSNR_LD = CNT_W'(`DIB_XSNR_CYC);

	// Elaboration stops on counts that the counters or the bank address cannot hold
	if (NUM_BANKS != 8 || BURST_LENGTH < 2 || READ_LATENCY < 2 ||
		WRAP_RD >= CNT_MAX || WR_ACCESS >= CNT_MAX || `DIB_XSNR_CYC >= CNT_MAX) begin : g_bad_cfg
		$error("dib_interbank: parameters out of range");
	end

	////////////////////////////////////////////////////////////////////////////
	// Decode

	function automatic dib_cmd_e decode(input dib_pins_s p, input logic cke_prev);
		logic [2:0] s;
		s = {p.row_strobe_n, p.col_strobe_n, p.write_enable_n};
		if (p.chip_select_n)
			decode = DIB_CMD_DESELECT;
		else if (s == 3'h7)
			decode = DIB_CMD_NOP;
		else if (s == 3'h1 && cke_prev && !p.clock_enable)
			decode = DIB_CMD_SELF_REFRESH;
		else if (!(cke_prev && p.clock_enable))
			decode = DIB_CMD_OTHER;
		else begin
			case (s)
				3'h3:    decode = DIB_CMD_ACTIVATE;
				3'h5:    decode = DIB_CMD_READ;
				3'h4:    decode = DIB_CMD_WRITE;
				3'h2:    decode = DIB_CMD_PRECHARGE;
				3'h1:    decode = DIB_CMD_REFRESH;
				3'h0:    decode = DIB_CMD_LOAD_MODE;
				default: decode = DIB_CMD_OTHER;
			endcase
		end
	endfunction

	logic                 cke_prev_q;
	logic [CNT_W-1:0]     xsnr_cnt_q;
	logic [CNT_W-1:0]     since_wrap_q;
	logic [CNT_W-1:0]     since_rdap_q;

	wire dib_cmd_e cmd_w    = decode(pins, cke_prev_q);
	wire logic [2:0] ba_w   = pins.bank_addr;
	wire logic ap_w         = pins.auto_precharge_select_bit;
	wire logic gate_ok      = cke_prev_q && pins.clock_enable && !exit_pending_q;
	wire dib_bank_e tgt_w   = bank_state_q[ba_w];

	////////////////////////////////////////////////////////////////////////////
	// Legality

	logic [NUM_BANKS-1:0] idle_vec;
	logic [NUM_BANKS-1:0] activating_vec;

	// Spacing after auto precharge bursts in other banks
	wire logic wrap_rd_ok = since_wrap_q >= CNT_W'(WRAP_RD);
	wire logic wrap_wr_ok = since_wrap_q >= HBL_LD;
	wire logic rdap_rd_ok = since_rdap_q >= HBL_LD;
	wire logic rdap_wr_ok = since_rdap_q >= CNT_W'(RDAP_WR);
	wire logic ap_any_ok  = (since_wrap_q >= 1) && (since_rdap_q >= 1);

	wire logic tgt_open   = tgt_w == DIB_BANK_ACTIVE || tgt_w == DIB_BANK_READING ||
	                        tgt_w == DIB_BANK_WRITING;

	logic legal_w;
	always_comb begin
		legal_w = 1'b0;
		case (cmd_w)
			DIB_CMD_DESELECT, DIB_CMD_NOP: legal_w = 1'b1;
			DIB_CMD_ACTIVATE:  legal_w = gate_ok && tgt_w == DIB_BANK_IDLE && ap_any_ok;
			DIB_CMD_READ:      legal_w = gate_ok && tgt_open && wrap_rd_ok && rdap_rd_ok;
			DIB_CMD_WRITE:     legal_w = gate_ok && tgt_open && wrap_wr_ok && rdap_wr_ok;
			DIB_CMD_PRECHARGE: legal_w = gate_ok && ap_any_ok &&
			                     (ap_w ? ~|activating_vec : tgt_w != DIB_BANK_ACTIVATING);
			DIB_CMD_REFRESH, DIB_CMD_LOAD_MODE: legal_w = gate_ok && &idle_vec;
			DIB_CMD_SELF_REFRESH: legal_w = &idle_vec && !exit_pending_q;
			default:           legal_w = 1'b0;
		endcase
	end

	wire logic real_cmd = cmd_w != DIB_CMD_DESELECT && cmd_w != DIB_CMD_NOP;
	wire logic take_w   = legal_w && real_cmd;

	////////////////////////////////////////////////////////////////////////////
	// Per-bank trackers

	genvar gi;
	generate
		for (gi = 0; gi < NUM_BANKS; gi++) begin : g_bank
			logic [CNT_W-1:0] cnt_q;
			logic [CNT_W-1:0] cnt_d;
			dib_bank_e        st_d;
			wire logic hit = take_w && (ba_w == 3'(gi));
			wire logic pre_hit = take_w && cmd_w == DIB_CMD_PRECHARGE && (ap_w || ba_w == 3'(gi));
			wire logic done = cnt_q == CNT_W'(1);

			assign idle_vec[gi]       = bank_state_q[gi] == DIB_BANK_IDLE;
			assign activating_vec[gi] = bank_state_q[gi] == DIB_BANK_ACTIVATING;

			always_comb begin
				st_d  = bank_state_q[gi];
				cnt_d = (cnt_q != '0) ? cnt_q - CNT_W'(1) : cnt_q;
				if (pre_hit) begin
					if (bank_state_q[gi] != DIB_BANK_IDLE) begin
						st_d  = DIB_BANK_PRECHARGING; // Last precharge sets the period
						cnt_d = RP_LD;
					end
				end else if (hit && cmd_w == DIB_CMD_ACTIVATE) begin
					st_d  = DIB_BANK_ACTIVATING;
					cnt_d = RCD_LD;
				end else if (hit && cmd_w == DIB_CMD_READ) begin
					st_d  = ap_w ? DIB_BANK_RD_AP_ACCESS : DIB_BANK_READING;
					cnt_d = HBL_LD;
				end else if (hit && cmd_w == DIB_CMD_WRITE) begin
					st_d  = ap_w ? DIB_BANK_WR_AP_ACCESS : DIB_BANK_WRITING;
					cnt_d = WRA_LD;
				end else if (done) begin
					case (bank_state_q[gi])
						DIB_BANK_ACTIVATING: st_d = DIB_BANK_ACTIVE;
						DIB_BANK_READING, DIB_BANK_WRITING: st_d = DIB_BANK_ACTIVE;
						DIB_BANK_RD_AP_ACCESS, DIB_BANK_WR_AP_ACCESS: begin
							st_d  = DIB_BANK_PRECHARGING;
							cnt_d = RP_LD;
						end
						DIB_BANK_PRECHARGING: st_d = DIB_BANK_IDLE;
						default: st_d = bank_state_q[gi];
					endcase
				end
			end

			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					bank_state_q[gi] <= DIB_BANK_IDLE;
					cnt_q            <= '0;
				end else begin
					bank_state_q[gi] <= st_d;
					cnt_q            <= cnt_d;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Spacing counters, self refresh and verdict

	// Saturate so an old burst never blocks later commands
	function automatic logic [CNT_W-1:0] age(input logic [CNT_W-1:0] c);
		age = (c == CNT_W'(CNT_MAX)) ? c : c + CNT_W'(1);
	endfunction

	wire logic wrap_now = take_w && cmd_w == DIB_CMD_WRITE && ap_w;
	wire logic rdap_now = take_w && cmd_w == DIB_CMD_READ && ap_w;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cke_prev_q   <= 1'b0;
			since_wrap_q <= CNT_W'(CNT_MAX);
			since_rdap_q <= CNT_W'(CNT_MAX);
		end else begin
			cke_prev_q   <= pins.clock_enable;
			since_wrap_q <= wrap_now ? CNT_W'(1) : age(since_wrap_q);
			since_rdap_q <= rdap_now ? CNT_W'(1) : age(since_rdap_q);
		end
	end

	// Self refresh entry and the exit wait
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			self_refresh_q <= 1'b0;
			exit_pending_q <= 1'b0;
			xsnr_cnt_q     <= '0;
		end else if (take_w && cmd_w == DIB_CMD_SELF_REFRESH) begin
			self_refresh_q <= 1'b1;
		end else if (self_refresh_q && pins.clock_enable) begin
			self_refresh_q <= 1'b0;
			exit_pending_q <= 1'b1;
			xsnr_cnt_q     <= XSNR_LD;
		end else if (exit_pending_q) begin
			xsnr_cnt_q     <= xsnr_cnt_q - CNT_W'(1);
			exit_pending_q <= xsnr_cnt_q > CNT_W'(1);
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cmd_accept_q <= 1'b0;
			cmd_reject_q <= 1'b0;
			last_cmd_q   <= '{cmd: DIB_CMD_DESELECT, bank: 3'h0, auto_pre: 1'b0};
			all_idle_q   <= 1'b1;
		end else begin
			cmd_accept_q <= take_w;
			cmd_reject_q <= real_cmd && !legal_w;
			if (real_cmd)
				last_cmd_q <= '{cmd: cmd_w, bank: ba_w, auto_pre: ap_w};
			all_idle_q   <= &idle_vec;
		end
	end

endmodule : dib_interbank

`default_nettype wire

// File: testbench/dib_interbank_props.sv
// Checker for command verdicts and bank phases at the block ports.
// Assumes default timing: activate and precharge 4 cycles, latency 4, burst 4.
`default_nettype none
module dib_interbank_props
	import dib_pkg::*;
#(
	parameter int NUM_BANKS = 8
) (
	// Clock and reset
	input wire logic                      ref_clk,
	input wire logic                      rst,
	// Pins and verdicts
	input wire dib_pins_s                 pins,
	input wire logic                      cmd_accept_q,
	input wire logic                      cmd_reject_q,
	input wire dib_cmd_s                  last_cmd_q,
	input wire dib_bank_e [NUM_BANKS-1:0] bank_state_q
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	wire logic      ok = cmd_accept_q;
	wire logic      no = cmd_reject_q;
	wire dib_cmd_e  lc = last_cmd_q.cmd;
	wire dib_bank_e b0 = bank_state_q[0];
	wire logic      wr_ap = ok && lc == DIB_CMD_WRITE && last_cmd_q.auto_pre;
	wire logic      rd_ap = ok && lc == DIB_CMD_READ && last_cmd_q.auto_pre;
	a_desel_quiet: assert property ($past(pins.chip_select_n) |-> !ok && !no)
		else $error("verdict after deselect");
	a_nop_quiet: assert property ($past(pins[8:5]) == 4'h7 |-> !ok && !no)
		else $error("verdict after no-operation");
	a_act_decode: assert property (ok && lc == DIB_CMD_ACTIVATE |->
		$past(pins[8:5]) == 4'h3 && $past(pins.bank_addr) == last_cmd_q.bank)
		else $error("activate accepted from wrong pins");
	a_cke_twice: assert property (ok && lc != DIB_CMD_SELF_REFRESH |->
		$past(pins.clock_enable) && $past(pins.clock_enable, 2))
		else $error("accept without clock enable twice");
	a_refresh_idle: assert property (ok && lc == DIB_CMD_REFRESH |->
		$past(bank_state_q) == {NUM_BANKS{DIB_BANK_IDLE}})
		else $error("refresh accepted with busy bank");
	a_act_span: assert property ($rose(b0 == DIB_BANK_ACTIVATING) |->
		(b0 == DIB_BANK_ACTIVATING) [*4] ##1 b0 == DIB_BANK_ACTIVE)
		else $error("activate phase length wrong");
	a_rdap_phase: assert property ($rose(b0 == DIB_BANK_RD_AP_ACCESS) |->
		(b0 == DIB_BANK_RD_AP_ACCESS) [*2] ##1 (b0 == DIB_BANK_PRECHARGING) [*4]
		##1 b0 == DIB_BANK_IDLE)
		else $error("read auto precharge phases wrong");
	a_wrap_read: assert property (wr_ap |=> !(ok && lc == DIB_CMD_READ) [*6])
		else $error("read too soon after write auto precharge");
	a_rdap_write: assert property (rd_ap |=> !(ok && lc == DIB_CMD_WRITE) [*3])
		else $error("write too soon after read auto precharge");
	c_act: cover property (ok && lc == DIB_CMD_ACTIVATE);
	c_refused: cover property (no);
	c_wr_ap: cover property (b0 == DIB_BANK_WR_AP_ACCESS);
	c_refresh: cover property (ok && lc == DIB_CMD_REFRESH);
	c_self: cover property (ok && lc == DIB_CMD_SELF_REFRESH);
endmodule // dib_interbank_props
bind dib_interbank dib_interbank_props #(.NUM_BANKS(NUM_BANKS)) u_props (
	.ref_clk(ref_clk), .rst(rst), .pins(pins), .cmd_accept_q(cmd_accept_q),
	.cmd_reject_q(cmd_reject_q), .last_cmd_q(last_cmd_q), .bank_state_q(bank_state_q));
`default_nettype wire

// File: testbench/dib_ctl_model.sv
// Controller stand-in that drives the command pins.
// Assumes each call starts at a rising ref_clk edge.
`default_nettype none
module dib_ctl_model
	import dib_pkg::*;
(
	// Clock
	input wire logic      ref_clk,
	// Command pins
	output var dib_pins_s pins
);
	timeunit 1ns;
	timeprecision 1ps;
	// Levels change with the edge, so each command is taken exactly once
	task automatic send(input logic [3:0] strobes, input logic ap, input logic [2:0] bank,
			input logic cke);
		pins <= {strobes, cke, ap, bank};
		@(posedge ref_clk);
	endtask
endmodule // dib_ctl_model
`default_nettype wire

// File: testbench/test_dib_interbank.sv
// Self-checking bench for the inter-bank command checker.
// Assumes the default timing constants of dib_cfg.svh.
`default_nettype none
`include "dib_cfg.svh"
module test_dib_interbank
	import dib_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [3:0] ACT = 4'h3, RD = 4'h5, WR = 4'h4, PRE = 4'h2, REF = 4'h1;
	localparam logic [3:0] NOP = 4'h7, DSL = 4'hB, LM = 4'h0;
	localparam int HB = `DIB_BURST_LENGTH / 2;
	localparam int W2R = `DIB_READ_LATENCY - 1 + HB + `DIB_WTR_CYC;
	logic            ref_clk = 1'b0;
	logic            rst;
	wire dib_pins_s  pins;
	logic            acc;
	logic            rej;
	dib_bank_e [7:0] bst;
	logic            idl;
	logic            srf;
	logic            xpd;
	logic [1:0]      want = 2'b00;
	logic            rcare = 1'b1;
	int              fail_count = 0;
	int              checks_done = 0;

	always #2 ref_clk = ~ref_clk;

	dib_ctl_model u_ctl (.ref_clk(ref_clk), .pins(pins));
	dib_interbank DUT (.ref_clk(ref_clk), .rst(rst), .pins(pins), .cmd_accept_q(acc),
		.cmd_reject_q(rej), .last_cmd_q(), .bank_state_q(bst), .all_idle_q(idl),
		.self_refresh_q(srf), .exit_pending_q(xpd));

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	// Verdict of the previous edge's command is settled when the next edge arrives
	task automatic take(input logic [3:0] c, input logic ap, input logic [2:0] b,
			input logic cke, input logic [1:0] w, input logic rc);
		u_ctl.send(c, ap, b, cke);
		check("accept", 8'(want[1]), 8'(acc));
		if (rcare) check("reject", 8'(want[0]), 8'(rej));
		want = w;
		rcare = rc;
	endtask

	task automatic idle(input int n);
		repeat (n) take(NOP, 1'b0, 3'h0, 1'b1, 2'b00, 1'b1);
	endtask

	task automatic st(input int b, input dib_bank_e e);
		check("bank state", 8'(e), 8'(bst[b]));
	endtask

	task automatic do_reset();
		rst <= 1'b1;
		idle(12);
		rst <= 1'b0;
		idle(2);
	endtask

	task automatic t_basic();
		do_reset();
		take(DSL, 1'b0, 3'h0, 1'b1, 2'b00, 1'b1);
		take(RD, 1'b0, 3'h2, 1'b1, 2'b01, 1'b1);
		take(ACT, 1'b0, 3'h0, 1'b1, 2'b10, 1'b1);
		take(ACT, 1'b0, 3'h1, 1'b1, 2'b10, 1'b1);
		take(DSL, 1'b0, 3'h0, 1'b1, 2'b00, 1'b1);
		st(0, DIB_BANK_ACTIVATING);
		take(NOP, 1'b0, 3'h0, 1'b1, 2'b00, 1'b1);
		take(REF, 1'b0, 3'h0, 1'b1, 2'b01, 1'b1);
		take(ACT, 1'b0, 3'h0, 1'b1, 2'b01, 1'b1);
		st(0, DIB_BANK_ACTIVE);
		take(ACT, 1'b0, 3'h2, 1'b0, 2'b00, 1'b0);
		take(ACT, 1'b0, 3'h2, 1'b1, 2'b00, 1'b0);
		take(ACT, 1'b0, 3'h2, 1'b1, 2'b10, 1'b1);
		take(PRE, 1'b1, 3'h0, 1'b1, 2'b01, 1'b1);
		check("all idle", 8'h00, 8'(idl));
		idle(3);
		take(PRE, 1'b1, 3'h0, 1'b1, 2'b10, 1'b1);
		idle(1);
		st(1, DIB_BANK_PRECHARGING);
	endtask

	// Self refresh entry, the exit wait, then mode load only with every bank idle
	task automatic t_self();
		do_reset();
		take(REF, 1'b0, 3'h0, 1'b0, 2'b10, 1'b1);
		take(NOP, 1'b0, 3'h0, 1'b0, 2'b00, 1'b1);
		check("self refresh", 8'h01, 8'(srf));
		take(NOP, 1'b0, 3'h0, 1'b1, 2'b00, 1'b1);
		take(ACT, 1'b0, 3'h0, 1'b1, 2'b01, 1'b1);
		check("exit wait", 8'h01, 8'(xpd));
		idle(`DIB_XSNR_CYC - 2);
		take(LM, 1'b0, 3'h0, 1'b1, 2'b01, 1'b1);
		check("exit wait", 8'h01, 8'(xpd));
		take(LM, 1'b0, 3'h0, 1'b1, 2'b10, 1'b1);
		check("exit wait", 8'h00, 8'(xpd));
		take(ACT, 1'b0, 3'h0, 1'b1, 2'b10, 1'b1);
		check("all idle", 8'h01, 8'(idl));
		take(LM, 1'b0, 3'h0, 1'b1, 2'b01, 1'b1);
		idle(1);
		check("all idle", 8'h00, 8'(idl));
	endtask

	task automatic t_phases(input logic wr, input int n);
		dib_bank_e ph;
		ph = wr ? DIB_BANK_WR_AP_ACCESS : DIB_BANK_RD_AP_ACCESS;
		do_reset();
		take(ACT, 1'b0, 3'h0, 1'b1, 2'b10, 1'b1);
		idle(5);
		take(wr ? WR : RD, 1'b1, 3'h0, 1'b1, 2'b10, 1'b1);
		idle(1);
		st(0, ph);
		idle(n - 1);
		st(0, ph);
		idle(1);
		st(0, DIB_BANK_PRECHARGING);
		idle(`DIB_RP_CYC - 1);
		st(0, DIB_BANK_PRECHARGING);
		idle(1);
		st(0, DIB_BANK_IDLE);
		idle(2);
		take(REF, 1'b0, 3'h0, 1'b1, 2'b10, 1'b1);
		idle(1);
	endtask

	// Second command to another bank, gap edges after an auto precharge access
	task automatic t_gap(input logic [3:0] f, input logic [3:0] s, input logic [2:0] b,
			input int gap, input logic ok);
		do_reset();
		take(ACT, 1'b0, 3'h0, 1'b1, 2'b10, 1'b1);
		take(ACT, 1'b0, 3'h1, 1'b1, 2'b10, 1'b1);
		idle(5);
		take(f, 1'b1, 3'h0, 1'b1, 2'b10, 1'b1);
		idle(gap - 1);
		take(s, 1'b0, b, 1'b1, {ok, !ok}, 1'b1);
		idle(1);
	endtask

	task automatic finish_test();
		if (fail_count == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// About 420 cycles are needed; a generous margin guards against a stuck run
	initial begin
		repeat (4000) @(posedge ref_clk);
		fail_count++;
		finish_test();
	end

	initial begin
		t_basic();
		t_self();
		t_phases(1'b0, HB);
		t_phases(1'b1, `DIB_READ_LATENCY - 1 + HB + `DIB_WR_CYC);
		t_gap(WR, RD, 3'h1, W2R - 1, 1'b0);
		t_gap(WR, RD, 3'h1, W2R, 1'b1);
		t_gap(WR, WR, 3'h1, HB - 1, 1'b0);
		t_gap(WR, WR, 3'h1, HB, 1'b1);
		t_gap(RD, RD, 3'h1, HB - 1, 1'b0);
		t_gap(RD, RD, 3'h1, HB, 1'b1);
		t_gap(RD, WR, 3'h1, HB + 1, 1'b0);
		t_gap(RD, WR, 3'h1, HB + 2, 1'b1);
		t_gap(WR, ACT, 3'h2, 1, 1'b1);
		t_gap(RD, PRE, 3'h1, 1, 1'b1);
		finish_test();
	end
endmodule // test_dib_interbank
`default_nettype wire
